// ### inc/nand_feat_pkg.sv
// Constants, field layouts and carriers for the feature-command host.
// Assumes a 200 MHz pclk and an asynchronous NAND target on plain pins.
// Summary of operation
// - Feature commands only while every die idle
// - One address cycle, then wait tADL
// - After status polling, issue READ MODE first
// - Read four parameter bytes in order
// - Mode in bits 2:0; modes 0-4 only
// - Pick mode matching fastest host cycle rate
// - Relax bus timing below full drive strength
// - 90h with 08h enables ECC, 00h disables
package nand_feat_pkg;

   // ==================================================================
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_ADL_NS = 70;
   localparam int T_WHR_NS = 60;
   localparam int T_WB_NS = 100;
   localparam logic [7:0] ADL_CYC = 8'((T_ADL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] WHR_CYC = 8'((T_WHR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] WB_CYC = 8'((T_WB_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] PACE_RESET = 8'h04;
   localparam logic [7:0] PACE_MIN = 8'h04;
   localparam logic [7:0] RELAX_EXTRA = 8'h02;

   // ==================================================================
   // Target commands, feature addresses and parameter encodings
   localparam logic [7:0] CMD_SET_FEAT = 8'hef;
   localparam logic [7:0] CMD_GET_FEAT = 8'hee;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_MODE = 8'h00;
   localparam logic [7:0] FA_TIMING = 8'h01;
   localparam logic [7:0] FA_DRIVE = 8'h80;
   localparam logic [7:0] FA_PULLDN = 8'h81;
   localparam logic [7:0] FA_ARRAY = 8'h90;
   localparam logic [7:0] MASK_TIMING = 8'h07;
   localparam logic [7:0] MASK_STRENGTH = 8'h03;
   localparam logic [7:0] ECC_ON = 8'h08;
   localparam logic [7:0] ECC_OFF = 8'h00;
   localparam logic [7:0] TMODE_MAX = 8'h04;
   localparam int SR_READY_BIT = 6;

   // ==================================================================
   // APB register map of the host
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_FADDR = 12'h004;
   localparam logic [11:0] OFF_WPARAM = 12'h008;
   localparam logic [11:0] OFF_RPARAM = 12'h00c;
   localparam logic [11:0] OFF_STATUS = 12'h010;
   localparam logic [11:0] OFF_PACE = 12'h014;
   localparam logic [11:0] OFF_SHADOW = 12'h018;
   localparam int CTRL_START = 0;
   localparam int CTRL_GET = 1;
   localparam int CTRL_POLL = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_READY = 3;
   localparam int SH_TMODE_LSB = 0;
   localparam int SH_DRIVE_LSB = 8;
   localparam int SH_PULLDN_LSB = 16;
   localparam int SH_ECC_BIT = 24;

   // ==================================================================
   // Carriers
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic io_oe;
      logic [7:0] io_out;
   } nand_out_s;

   typedef struct packed {
      logic [7:0] fourth_param_byte;
      logic [7:0] third_param_byte;
      logic [7:0] second_param_byte;
      logic [7:0] first_param_byte;
   } params_s;

   localparam nand_out_s PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                       re_n: 1'b1, io_oe: 1'b0, io_out: 8'h00};

endpackage

// ### logic/pace_divider.sv
// Strobe pacing divider: one-cycle tick every period cycles while run.
// Assumes period is at least two; the caller clamps its base to 4, but adding the relax extra wraps 254 and 255 to 0 and 1.
`timescale 1ns/1ps
module pace_divider #(
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [W-1:0] period,
   output logic tick
);
   logic [W-1:0] cnt_reg;

   if (W < 2) $error("pace_divider W too small");

   // Restarts from zero each operation so the first strobe is a full period away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else if (!run || tick) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // Tick on the last count of the period
   assign tick = run && (cnt_reg >= period - 1'b1);

endmodule // pace_divider

// ### logic/nand_feature_host.sv
// Host controller issuing set-features and get-features to a NAND target.
// Assumes software on APB and a target wired to the pin struct and rb_n.
`timescale 1ns/1ps
module nand_feature_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic rb_n,
   input wire logic [7:0] io_in,
   output nand_feat_pkg::nand_out_s nand_out
);

   typedef enum {
      S_IDLE, S_CMD, S_ADDR, S_ADL, S_WDATA, S_WB, S_RBWAIT,
      S_STCMD, S_STWHR, S_STRD, S_MODECMD, S_WHR, S_RDATA
   } state_e;

   state_e state_reg;
   logic half_reg;
   logic [1:0] byte_reg;
   logic [7:0] wait_reg;
   nand_feat_pkg::nand_out_s out_reg;
   nand_feat_pkg::params_s op_params_reg;
   logic [7:0] op_faddr_reg;
   logic op_get_reg;
   logic op_poll_reg;
   logic [31:0] rparam_reg;
   logic done_pulse_reg;
   logic rb_meta_reg, rb_sync_reg;
   logic [7:0] io_meta_reg, io_sync_reg;
   logic [7:0] faddr_reg;
   logic [31:0] wparam_reg;
   logic [7:0] pace_reg;
   logic done_reg, refused_reg;
   logic [2:0] tmode_reg;
   logic [1:0] drive_reg, pulldn_reg;
   logic ecc_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic addr_hit, wr_en, launch, params_ok, go_ok, tick;
   logic [7:0] pace_eff;
   nand_feat_pkg::params_s clean_params;

   // ==================================================================
   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_meta_reg <= 1'b0;
         rb_sync_reg <= 1'b0;
         io_meta_reg <= 8'h00;
         io_sync_reg <= 8'h00;
      end else begin
         rb_meta_reg <= rb_n;
         rb_sync_reg <= rb_meta_reg;
         io_meta_reg <= io_in;
         io_sync_reg <= io_meta_reg;
      end
   end

   // ==================================================================
   // APB slave, zero wait states; read data captured in setup
   assign pready = psel & penable;
   assign wr_en = psel & penable & pwrite;
   assign pslverr = psel & penable & ~addr_hit;
   assign prdata = prdata_reg;
   assign launch = wr_en && paddr == nand_feat_pkg::OFF_CTRL &&
                   pwdata[nand_feat_pkg::CTRL_START] && state_reg == S_IDLE;

   // Decode and read mux
   always_comb begin
      addr_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         nand_feat_pkg::OFF_CTRL: rd_mux = 32'h0000_0000;
         nand_feat_pkg::OFF_FADDR: rd_mux = {24'h00_0000, faddr_reg};
         nand_feat_pkg::OFF_WPARAM: rd_mux = wparam_reg;
         nand_feat_pkg::OFF_RPARAM: rd_mux = rparam_reg;
         nand_feat_pkg::OFF_PACE: rd_mux = {24'h00_0000, pace_reg};
         nand_feat_pkg::OFF_STATUS: begin
            rd_mux[nand_feat_pkg::ST_BUSY] = state_reg != S_IDLE;
            rd_mux[nand_feat_pkg::ST_DONE] = done_reg;
            rd_mux[nand_feat_pkg::ST_REFUSED] = refused_reg;
            rd_mux[nand_feat_pkg::ST_READY] = rb_sync_reg;
         end
         nand_feat_pkg::OFF_SHADOW: begin
            rd_mux[nand_feat_pkg::SH_TMODE_LSB +: 3] = tmode_reg;
            rd_mux[nand_feat_pkg::SH_DRIVE_LSB +: 2] = drive_reg;
            rd_mux[nand_feat_pkg::SH_PULLDN_LSB +: 2] = pulldn_reg;
            rd_mux[nand_feat_pkg::SH_ECC_BIT] = ecc_reg;
         end
         default: addr_hit = 1'b0;
      endcase
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_reg <= rd_mux;
      end
   end

   // Software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         faddr_reg <= 8'h00;
         wparam_reg <= 32'h0000_0000;
         pace_reg <= nand_feat_pkg::PACE_RESET;
      end else if (wr_en) begin
         if (paddr == nand_feat_pkg::OFF_FADDR) begin
            faddr_reg <= pwdata[7:0];
         end
         if (paddr == nand_feat_pkg::OFF_WPARAM) begin
            wparam_reg <= pwdata;
         end
         if (paddr == nand_feat_pkg::OFF_PACE) begin
            // Clamp keeps strobes long enough for the synchronised sample
            pace_reg <= (pwdata[7:0] < nand_feat_pkg::PACE_MIN) ?
                        nand_feat_pkg::PACE_MIN : pwdata[7:0];
         end
      end
   end

   // ==================================================================
   // Launch checks and parameter cleaning
   always_comb begin
      clean_params = '0;
      params_ok = 1'b1;
      case (faddr_reg)
         nand_feat_pkg::FA_TIMING: begin
            clean_params.first_param_byte = wparam_reg[7:0] & nand_feat_pkg::MASK_TIMING;
            params_ok = clean_params.first_param_byte <= nand_feat_pkg::TMODE_MAX;
         end
         nand_feat_pkg::FA_DRIVE, nand_feat_pkg::FA_PULLDN: begin
            clean_params.first_param_byte = wparam_reg[7:0] & nand_feat_pkg::MASK_STRENGTH;
         end
         nand_feat_pkg::FA_ARRAY: begin
            clean_params.first_param_byte = wparam_reg[7:0];
            params_ok = wparam_reg[7:0] == nand_feat_pkg::ECC_ON ||
                        wparam_reg[7:0] == nand_feat_pkg::ECC_OFF;
         end
         default: params_ok = pwdata[nand_feat_pkg::CTRL_GET];
      endcase
      if (pwdata[nand_feat_pkg::CTRL_GET]) begin
         params_ok = 1'b1;
      end
   end

   // Refuse while any die is busy or the settings are not encodable
   assign go_ok = launch && rb_sync_reg && params_ok;

   // Sticky completion and refusal; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         if (done_pulse_reg) begin
            done_reg <= 1'b1;
         end else if (wr_en && paddr == nand_feat_pkg::OFF_STATUS &&
                      pwdata[nand_feat_pkg::ST_DONE]) begin
            done_reg <= 1'b0;
         end
         if (launch && !go_ok) begin
            refused_reg <= 1'b1;
         end else if (wr_en && paddr == nand_feat_pkg::OFF_STATUS &&
                      pwdata[nand_feat_pkg::ST_REFUSED]) begin
            refused_reg <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Strobe pacing; weaker output drive stretches every cycle
   assign pace_eff = (drive_reg != 2'b00) ?
                     8'(pace_reg + nand_feat_pkg::RELAX_EXTRA) : pace_reg;

   pace_divider #(.W(8)) u_pace (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_reg != S_IDLE),
      .period(pace_eff),
      .tick(tick)
   );

   assign nand_out = out_reg;

   // ==================================================================
   // Pin sequencer: each pin cycle is strobe low on one tick, high on the next
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         half_reg <= 1'b0;
         byte_reg <= 2'd0;
         wait_reg <= 8'h00;
         out_reg <= nand_feat_pkg::PINS_IDLE;
         op_params_reg <= '0;
         op_faddr_reg <= 8'h00;
         op_get_reg <= 1'b0;
         op_poll_reg <= 1'b0;
         rparam_reg <= 32'h0000_0000;
         done_pulse_reg <= 1'b0;
      end else begin
         done_pulse_reg <= 1'b0;
         if (wait_reg != 8'h00) begin
            wait_reg <= wait_reg - 8'h01;
         end
         case (state_reg)
            S_IDLE: begin
               if (go_ok) begin
                  op_params_reg <= clean_params;
                  op_faddr_reg <= faddr_reg;
                  op_get_reg <= pwdata[nand_feat_pkg::CTRL_GET];
                  op_poll_reg <= pwdata[nand_feat_pkg::CTRL_POLL];
                  out_reg.ce_n <= 1'b0;
                  out_reg.cle <= 1'b1;
                  out_reg.io_oe <= 1'b1;
                  out_reg.io_out <= pwdata[nand_feat_pkg::CTRL_GET] ?
                                    nand_feat_pkg::CMD_GET_FEAT :
                                    nand_feat_pkg::CMD_SET_FEAT;
                  half_reg <= 1'b0;
                  state_reg <= S_CMD;
               end
            end
            S_CMD, S_ADDR, S_WDATA, S_STCMD, S_MODECMD: begin
               if (tick && !half_reg) begin
                  out_reg.we_n <= 1'b0;
                  half_reg <= 1'b1;
               end else if (tick) begin
                  out_reg.we_n <= 1'b1;
                  half_reg <= 1'b0;
                  case (state_reg)
                     S_CMD: begin
                        out_reg.cle <= 1'b0;
                        out_reg.ale <= 1'b1;
                        out_reg.io_out <= op_faddr_reg;
                        state_reg <= S_ADDR;
                     end
                     S_ADDR: begin
                        out_reg.ale <= 1'b0;
                        if (op_get_reg) begin
                           out_reg.io_oe <= 1'b0;
                           wait_reg <= nand_feat_pkg::WB_CYC;
                           state_reg <= S_WB;
                        end else begin
                           wait_reg <= nand_feat_pkg::ADL_CYC;
                           state_reg <= S_ADL;
                        end
                     end
                     S_WDATA: begin
                        if (byte_reg == 2'd3) begin
                           out_reg.io_oe <= 1'b0;
                           wait_reg <= nand_feat_pkg::WB_CYC;
                           state_reg <= S_WB;
                        end else begin
                           byte_reg <= byte_reg + 2'd1;
                           out_reg.io_out <= op_params_reg[8 * (byte_reg + 2'd1) +: 8];
                        end
                     end
                     S_STCMD: begin
                        out_reg.cle <= 1'b0;
                        out_reg.io_oe <= 1'b0;
                        wait_reg <= nand_feat_pkg::WHR_CYC;
                        state_reg <= S_STWHR;
                     end
                     default: begin
                        out_reg.cle <= 1'b0; // READ MODE sent, data output follows
                        out_reg.io_oe <= 1'b0;
                        wait_reg <= nand_feat_pkg::WHR_CYC;
                        state_reg <= S_WHR;
                     end
                  endcase
               end
            end
            S_ADL: begin
               if (wait_reg == 8'h00) begin
                  byte_reg <= 2'd0;
                  out_reg.io_out <= op_params_reg.first_param_byte;
                  state_reg <= S_WDATA;
               end
            end
            S_WB: begin
               // Busy may take tWB to show, so neither poll nor trust rb_n earlier
               if (wait_reg == 8'h00) begin
                  if (op_poll_reg) begin
                     out_reg.cle <= 1'b1;
                     out_reg.io_oe <= 1'b1;
                     out_reg.io_out <= nand_feat_pkg::CMD_STATUS;
                     state_reg <= S_STCMD;
                  end else begin
                     state_reg <= S_RBWAIT;
                  end
               end
            end
            S_RBWAIT: begin
               // Wait covers tFEAT or the longer interface change alike
               if (rb_sync_reg) begin
                  if (op_get_reg) begin
                     wait_reg <= nand_feat_pkg::WHR_CYC;
                     state_reg <= S_WHR;
                  end else begin
                     out_reg <= nand_feat_pkg::PINS_IDLE;
                     done_pulse_reg <= 1'b1;
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_STWHR: begin
               if (wait_reg == 8'h00) begin
                  state_reg <= S_STRD;
               end
            end
            S_STRD, S_RDATA: begin
               if (tick && !half_reg) begin
                  out_reg.re_n <= 1'b0;
                  half_reg <= 1'b1;
               end else if (tick) begin
                  out_reg.re_n <= 1'b1;
                  half_reg <= 1'b0;
                  if (state_reg == S_RDATA) begin
                     rparam_reg[8 * byte_reg +: 8] <= io_sync_reg;
                     if (byte_reg == 2'd3) begin
                        out_reg <= nand_feat_pkg::PINS_IDLE;
                        done_pulse_reg <= 1'b1;
                        state_reg <= S_IDLE;
                     end else begin
                        byte_reg <= byte_reg + 2'd1;
                     end
                  end else if (io_sync_reg[nand_feat_pkg::SR_READY_BIT]) begin
                     if (op_get_reg) begin
                        out_reg.cle <= 1'b1;
                        out_reg.io_oe <= 1'b1;
                        out_reg.io_out <= nand_feat_pkg::CMD_READ_MODE;
                        state_reg <= S_MODECMD;
                     end else begin
                        out_reg <= nand_feat_pkg::PINS_IDLE;
                        done_pulse_reg <= 1'b1;
                        state_reg <= S_IDLE;
                     end
                  end
               end
            end
            S_WHR: begin
               if (wait_reg == 8'h00) begin
                  byte_reg <= 2'd0;
                  state_reg <= S_RDATA;
               end
            end
            default: begin
               out_reg <= nand_feat_pkg::PINS_IDLE;
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ==================================================================
   // Shadow of target settings; only a power-on reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmode_reg <= 3'd0;
         drive_reg <= 2'd0;
         pulldn_reg <= 2'd0;
         ecc_reg <= 1'b0;
      end else if (done_pulse_reg && !op_get_reg) begin
         case (op_faddr_reg)
            nand_feat_pkg::FA_TIMING: tmode_reg <= op_params_reg.first_param_byte[2:0];
            nand_feat_pkg::FA_DRIVE: drive_reg <= op_params_reg.first_param_byte[1:0];
            nand_feat_pkg::FA_PULLDN: pulldn_reg <= op_params_reg.first_param_byte[1:0];
            nand_feat_pkg::FA_ARRAY: ecc_reg <= op_params_reg.first_param_byte[3];
            default: ecc_reg <= ecc_reg;
         endcase
      end
   end

endmodule // nand_feature_host

// ### tb/nand_feat_chk.sv
// Checker for the feature-command host: APB answer and target pin rules.
// Assumes it is bound to nand_feature_host and sees only its ports.
`timescale 1ns/1ps
module nand_feat_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic rb_n,
   input wire logic [7:0] io_in,
   input wire nand_feat_pkg::nand_out_s nand_out
);
   // ==================================================================
   // Properties
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Write strobe opening while the target is selected
   sequence wr_low;
      $fell(nand_out.we_n) ##0 !nand_out.ce_n;
   endsequence
   chk_apb_ready: assert property (pready == (psel && penable)) else $error("pready wrong");
   chk_unmapped_err: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
      else $error("no error on unmapped");
   chk_mapped_ok: assert property (psel && penable && paddr <= 12'h018 |-> !pslverr)
      else $error("error on mapped");
   chk_idle_start: assert property ($fell(nand_out.ce_n) |-> $past(rb_n, 3))
      else $error("start while busy");
   chk_ce_strobe: assert property (!nand_out.we_n || !nand_out.re_n |-> !nand_out.ce_n)
      else $error("strobe without select");
   chk_read_released: assert property (!nand_out.re_n |-> !nand_out.io_oe)
      else $error("bus driven in read");
   chk_strobe_pace: assert property (wr_low |-> !nand_out.we_n [*4])
      else $error("write strobe short");
   chk_adl_gap: assert property ($rose(nand_out.we_n) && $past(nand_out.ale)
      |=> nand_out.we_n [*8]) else $error("address gap short");
   chk_param_zero: assert property (wr_low ##0 !nand_out.cle && !nand_out.ale && nand_out.io_oe
      |-> nand_out.io_out[7:4] == 4'h0) else $error("reserved bits set");
   chk_idle_bus: assert property (nand_out.ce_n |-> !nand_out.io_oe && nand_out.we_n)
      else $error("pins not idle");
endmodule // nand_feat_chk

// ### tb/nand_target_model.sv
// Behavioural NAND target holding the feature parameters.
// Assumes pins change on pclk; latches on the sampled rise of the strobes.
`timescale 1ns/1ps
module nand_target_model #(
   parameter int FEAT_CYC = 40
) (
   input wire logic pclk,
   input wire logic por_n,
   input wire logic hold_busy,
   input wire nand_feat_pkg::nand_out_s pins,
   input wire logic [7:0] bus,
   output logic rb_n,
   output logic [7:0] dq
);
   nand_feat_pkg::nand_out_s prev;
   logic [7:0] prev_bus, cmd, cur;
   logic [7:0] feat [4];
   logic [31:0] rd;
   logic [1:0] n;
   logic stat;
   int busy;
   function automatic logic [1:0] slot(input logic [7:0] a);
      return a == 8'h01 ? 2'h0 : a == 8'h80 ? 2'h1 : a == 8'h81 ? 2'h2 : 2'h3;
   endfunction
   // Cycle latch on the value held while the strobe was low
   always @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         feat <= '{default: 8'h00};
         busy <= 0;
         cmd <= 8'hff;
         n <= 2'h0;
         stat <= 1'b0;
         rd <= 32'h0;
         prev <= nand_feat_pkg::PINS_IDLE;
         prev_bus <= 8'h00;
      end else begin
         prev <= pins;
         prev_bus <= bus;
         if (busy > 0) busy <= busy - 1;
         if (pins.we_n && !prev.we_n && !prev.ce_n) begin
            if (prev.cle && (busy == 0 || prev_bus == 8'h70)) begin
               cmd <= prev_bus;
               n <= 2'h0;
               stat <= prev_bus == 8'h70;
            end else if (prev.ale && cmd == 8'hee) begin
               rd <= {24'h0, feat[slot(prev_bus)]};
               busy <= FEAT_CYC;
            end else if (prev.ale) rd <= {24'h0, prev_bus};
            else if (cmd == 8'hef) begin
               if (n == 2'h0) feat[slot(rd[7:0])] <= prev_bus;
               n <= n + 2'h1;
               if (n == 2'h3) busy <= FEAT_CYC;
            end
         end
         if (pins.re_n && !prev.re_n && !stat) rd <= rd >> 8;
      end
   end
   // Status shows ready live; dq shows the inverse value while re_n is high
   assign cur = stat ? {1'b1, busy == 0, 6'h00} : rd[7:0];
   assign dq = pins.re_n ? ~cur : cur;
   assign rb_n = busy == 0 && !hold_busy;
endmodule // nand_target_model

// ### tb/testbench.sv
// Testbench: APB driver with queued read checks against a target model.
// Assumes the package, host, model and checker are compiled before it.
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, sh = 32'h0;
   logic pready, pslverr, rb_n, hold = 1'b0, watch = 1'b0;
   logic [7:0] dq, io, v;
   logic [32:0] exp_q [$];
   nand_feat_pkg::nand_out_s nand_out;
   int errors = 0, tests_run = 0, seed = 32'h7a8e61a3, k;
   localparam logic [7:0] FAS [4] = '{8'h01, 8'h80, 8'h81, 8'h90};
   localparam logic [7:0] BAD_A [3] = '{8'h01, 8'h02, 8'h90};
   localparam logic [7:0] BAD_P [3] = '{8'h05, 8'h00, 8'h01};
   always #2.5 pclk = ~pclk;
   // Shared data wire: host wins while it drives
   assign io = nand_out.io_oe ? nand_out.io_out : dq;
   nand_feature_host u_nand_feature_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .rb_n, .io_in(io), .nand_out);
   nand_target_model u_nand_target_model (.pclk, .por_n(presetn), .hold_busy(hold),
      .pins(nand_out), .bus(io), .rb_n, .dq);
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
      tests_run++;
      if (seen !== want) begin
         errors++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Oldest note against the answer taken at the access edge
   always @(posedge pclk) if (psel && penable && pready && watch)
      check("apb answer", {pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
   // One APB transfer, then an idle cycle so psel is never assigned twice
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic c, input logic [32:0] e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      watch <= c;
      if (c) exp_q.push_back(e);
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      watch <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b1, {1'b0, e});
   endtask
   // Start with random poll choice and junk in the unused parameter bytes
   task automatic start(input logic g, input logic [7:0] a, input logic [7:0] p);
      wr(nand_feat_pkg::OFF_FADDR, {24'h0, a});
      wr(nand_feat_pkg::OFF_WPARAM, {24'($random(seed)), p});
      wr(nand_feat_pkg::OFF_CTRL, {29'h0, 1'($random(seed)), g, 1'b1});
   endtask
   task automatic wait_done();
      r = 32'h0;
      for (int i = 0; i < 400 && r[1] !== 1'b1; i++)
         apb(1'b0, nand_feat_pkg::OFF_STATUS, 32'h0, 1'b0, 33'h0);
      check("done", {32'h0, r[1]}, 33'h1);
      wr(nand_feat_pkg::OFF_STATUS, 32'h2);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(nand_feat_pkg::OFF_SHADOW, 32'h0);
      rd(nand_feat_pkg::OFF_PACE, 32'h4);
      wr(nand_feat_pkg::OFF_PACE, 32'h105);
      rd(nand_feat_pkg::OFF_PACE, 32'h5);
      apb(1'b1, 12'h020, 32'h0, 1'b1, {1'b1, 32'h0});
      $display("Test reset values done");
      for (int i = 0; i < 12; i++) begin
         k = $random(seed) & 3;
         v = 8'($random(seed));
         if (k == 0) v[2:0] = 3'(v[2:0] % 5);
         if (k == 3) v = v[0] ? 8'h08 : 8'h00;
         case (k)
            0: sh[2:0] = v[2:0];
            1: sh[9:8] = v[1:0];
            2: sh[17:16] = v[1:0];
            default: sh[24] = v[3];
         endcase
         start(1'b0, FAS[k], v);
         wait_done();
         rd(nand_feat_pkg::OFF_SHADOW, sh);
         start(1'b1, FAS[k], 8'h00);
         wait_done();
         rd(nand_feat_pkg::OFF_RPARAM, {24'h0, v & (k == 0 ? 8'h07 : k == 3 ? 8'hff : 8'h03)});
      end
      $display("Test set and get done");
      for (int i = 0; i < 3; i++) begin
         start(1'b0, BAD_A[i], BAD_P[i]);
         rd(nand_feat_pkg::OFF_STATUS, 32'hc);
         wr(nand_feat_pkg::OFF_STATUS, 32'h4);
      end
      hold <= 1'b1;
      repeat (4) @(posedge pclk);
      start(1'b0, 8'h80, 8'h01);
      rd(nand_feat_pkg::OFF_STATUS, 32'h4);
      hold <= 1'b0;
      wr(nand_feat_pkg::OFF_STATUS, 32'h4);
      rd(nand_feat_pkg::OFF_SHADOW, sh);
      $display("Test refusals done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(nand_feat_pkg::OFF_SHADOW, 32'h0);
      start(1'b1, 8'h80, 8'h00);
      wait_done();
      rd(nand_feat_pkg::OFF_RPARAM, 32'h0);
      $display("Test power cycle done");
      summarize();
   end
   // Hang guard, well beyond the expected run
   initial begin
      #300000;
      errors++;
      summarize();
   end
endmodule // testbench
bind nand_feature_host nand_feat_chk u_nand_feat_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .prdata, .pslverr, .rb_n, .io_in, .nand_out);
